// file: bench/accum_exec_props.sv
// Concurrent checks on the APB ports of the execution block.
`timescale 1ns/1ps
`default_nettype none

module accum_exec_props
	import exec_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence

	a_first_wait: assert property (s_access |-> !pready)
		else $error("ready in first access cycle");
	a_second_ready: assert property (s_access |=> pready)
		else $error("no ready in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_xfer: assert property (pready |-> psel && penable)
		else $error("ready outside a transfer");
	a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("error read returns data");
	a_status_ro: assert property (pready && pwrite && paddr == STATUS_OFF |-> pslverr)
		else $error("status write accepted");
	a_bad_opcode: assert property (pready && pwrite && paddr == CMD_OFF && pwdata[4:0] > 5'h10 |-> pslverr)
		else $error("unknown opcode accepted");
	a_acc_width: assert property (pready && !pwrite && paddr == ACC_OFF |-> prdata[31:8] == 24'h0)
		else $error("accumulator upper bits set");
	a_flag_width: assert property (pready && !pwrite && paddr == FLAGS_OFF |-> prdata[31:4] == 28'h0)
		else $error("flag upper bits set");
	a_unmapped: assert property (pready && (paddr > MEM_DATA_OFF || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped address accepted");
endmodule : accum_exec_props

`default_nettype wire

// file: bench/data_mem_model.sv
// Behavioural byte store standing for the data memory and stack area.
`timescale 1ns/1ps
`default_nettype none

module data_mem_model #(parameter int AW = 8);
	int b [1 << AW];

	// Only the low address bits reach the array, so a pointer high byte has no effect.
	function automatic int rd(input int a);
		return b[a % (1 << AW)];
	endfunction : rd

	function automatic void wr(input int a, input int v);
		b[a % (1 << AW)] = v & 255;
	endfunction : wr
endmodule : data_mem_model

`default_nettype wire

// file: bench/test_accum_exec_move_add_sub.sv
// Self-checking bench: every opcode in turn with random operands over APB against an integer model.
`timescale 1ns/1ps
`default_nettype none

module test_accum_move_add_sub_exec
	import exec_pkg::*;
;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] q;
	logic        e;
	int          error_cnt = 0;
	int          comparisons = 0;
	int unsigned rs = 32019;
	int          acc, fl, sp, i, op, o, wa, n, w;

	always #5 pclk = ~pclk;

	accum_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	data_mem_model m ();

	function automatic int unsigned rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd

	function automatic int sg(input int v);
		return v > 127 ? v - 256 : v;
	endfunction : sg

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n == 20)
		begin
			error_cnt++;
			$display("[FAIL] %0t no ready within 20 cycles", $time);
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input int d);
		apb(1'b1, a, d);
		chk(e, 0);
	endtask : wr

	task automatic rc(input logic [7:0] a, input int x);
		apb(1'b0, a, 0);
		chk(q, x);
	endtask : rc

	task automatic ref_exec();
		int x, y, ci, s, dm, r, mv, sr, cf;
		mv = m.rd(o);
		wa = o;
		x = acc;
		y = mv;
		cf = fl >> 1 & 1;
		ci = 0;
		s = 0;
		dm = 0;
		case (op)
			0: begin wa = mv; m.wr(wa, acc); return; end
			1: begin acc = m.rd(mv); return; end
			2: begin m.wr(o, acc); acc = mv; return; end
			3: begin wa = sp; m.wr(sp, acc); m.wr(sp + 1, fl); sp = (sp + 2) & 255; return; end
			4: begin sp = (sp + 254) & 255; acc = m.rd(sp); fl = m.rd(sp + 1) & 15; wa = sp; return; end
			5: y = o;
			6: ci = 0;
			7: dm = 1;
			8: ci = cf;
			9: begin ci = cf; dm = 1; end
			10: begin y = 0; ci = cf; end
			11: begin x = mv; y = 0; ci = cf; dm = 1; end
			12: begin x = mv; y = acc; s = 1; end
			13: begin s = 1; dm = 1; end
			14: begin y = o; s = 1; end
			15: s = 1;
			default: begin x = mv; y = acc; s = 1; dm = 1; end
		endcase
		sr = sg(x) + (s ? -sg(y) : sg(y) + ci);
		r = s ? x - y : x + y + ci;
		fl = 8 * (sr < -128 || sr > 127) + 4 * (s ? (x & 15) < (y & 15) : (x & 15) + (y & 15) + ci > 15)
			+ 2 * (s ? r < 0 : r > 255) + ((r & 255) == 0);
		r = r & 255;
		if (dm)
			m.wr(o, r);
		else
			acc = r;
	endtask : ref_exec

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	initial
	begin
		// About 10,000 cycles are expected, so three times that marks a hang.
		#300000;
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc(ACC_OFF, 0);
		rc(FLAGS_OFF, 0);
		rc(SP_OFF, 0);
		rc(STATUS_OFF, 0);
		$display("reset test done");
		for (i = 0; i < 256; i++)
		begin
			m.wr(i, rnd());
			wr(MEM_ADDR_OFF, i);
			wr(MEM_DATA_OFF, m.rd(i));
		end
		apb(1'b1, STATUS_OFF, 1);
		chk(e, 1);
		apb(1'b1, CMD_OFF, 17);
		chk(e, 1);
		apb(1'b0, 8'h1C, 0);
		chk(q, 0);
		chk(e, 1);
		$display("refusal test done");
		sp = rnd() & 255;
		wr(SP_OFF, sp);
		for (i = 0; i < 204; i++)
		begin
			op = i % 17;
			o = rnd() & 255;
			acc = rnd() & 255;
			fl = rnd() & 15;
			wr(ACC_OFF, acc);
			wr(FLAGS_OFF, fl);
			wr(CMD_OFF, op | o << 8);
			// The poll is bounded by its own count, since a single read always answers quickly.
			w = 0;
			do
			begin
				apb(1'b0, STATUS_OFF, 0);
				w++;
			end
			while (q[0] !== 1'b0 && w < 20);
			if (w == 20)
			begin
				error_cnt++;
				$display("[FAIL] %0t instruction never left busy", $time);
			end
			ref_exec();
			rc(ACC_OFF, acc);
			rc(FLAGS_OFF, fl);
			rc(SP_OFF, sp);
			wr(MEM_ADDR_OFF, wa);
			rc(MEM_DATA_OFF, m.rd(wa));
		end
		$display("instruction test done");
		final_report();
	end
endmodule : test_accum_move_add_sub_exec

bind accum_exec accum_exec_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire

// file: shared/exec_pkg.sv
// Constants, types and the arithmetic helper shared by the accumulator execution block.
`default_nettype none

package exec_pkg;

	localparam logic [7:0] CMD_OFF      = 8'h00;
	localparam logic [7:0] ACC_OFF      = 8'h04;
	localparam logic [7:0] FLAGS_OFF    = 8'h08;
	localparam logic [7:0] SP_OFF       = 8'h0C;
	localparam logic [7:0] STATUS_OFF   = 8'h10;
	localparam logic [7:0] MEM_ADDR_OFF = 8'h14;
	localparam logic [7:0] MEM_DATA_OFF = 8'h18;

	localparam int         CMD_OP_LSB   = 0;
	localparam int         CMD_OPND_LSB = 8;
	localparam int         STATUS_BUSY  = 0;

	localparam logic [7:0] ACC_RST      = 8'h00;
	localparam logic [3:0] FLAGS_RST    = 4'h0;
	localparam logic [7:0] SP_RST       = 8'h00;
	localparam logic [7:0] MADDR_RST    = 8'h00;
	localparam logic [7:0] SP_STEP      = 8'h02;

	typedef enum logic [4:0] {
		OP_IDXM_ST, OP_IDXM_LD, OP_XCH, OP_PUSHAF, OP_POPAF,
		OP_ADD_AI, OP_ADD_AM, OP_ADD_MA, OP_ADDC_AM, OP_ADDC_MA, OP_ADDC_A, OP_ADDC_M,
		OP_NADD_AM, OP_NADD_MA, OP_SUB_AI, OP_SUB_AM, OP_SUB_MA
	} op_e;

	typedef enum logic [1:0] {st_idle, st_issue, st_use, st_finish} state_e;

	typedef enum logic [1:0] {ysel_mem, ysel_imm, ysel_acc, ysel_zero} ysel_e;

	typedef struct packed {
		logic ov;
		logic ac;
		logic c;
		logic z;
	} flags_s;

	typedef struct packed {
		flags_s     flags;
		logic [7:0] res;
	} alu_s;

	typedef struct packed {
		logic [7:0] operand;
		logic [2:0] spare;
		op_e        op;
	} cmd_s;

	typedef struct packed {
		logic  arith;
		logic  mem_first;
		ysel_e ysel;
		logic  use_c;
		logic  is_sub;
		logic  dest_mem;
	} ctrl_s;

	// Subtraction is done as x plus the inverted y plus one, so both carries come out inverted as borrows.
	function automatic alu_s alu_calc(input logic [7:0] x, input logic [7:0] y, input logic cin,
		input logic is_sub);
		logic [7:0] ya;
		logic       ci;
		logic [4:0] lo;
		logic [4:0] hi;
		alu_s       r;
		ya         = is_sub ? ~y : y;
		ci         = is_sub ? 1'b1 : cin;
		lo         = {1'b0, x[3:0]} + {1'b0, ya[3:0]} + {4'h0, ci};
		hi         = {1'b0, x[7:4]} + {1'b0, ya[7:4]} + {4'h0, lo[4]};
		r.res      = {hi[3:0], lo[3:0]};
		r.flags.c  = hi[4] ^ is_sub;
		r.flags.ac = lo[4] ^ is_sub;
		r.flags.ov = (x[7] ^ ya[7] ^ r.res[7]) ^ hi[4];
		r.flags.z  = (r.res == 8'h00);
		return r;
	endfunction : alu_calc

endpackage : exec_pkg

`default_nettype wire

// file: src/accum_exec.sv
// Accumulator execution datapath with its data memory, driven over APB.
`timescale 1ns/1ps
`default_nettype none

module accum_exec
	import exec_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	if (AW < 2 || AW > 8)
	begin : g_bad_aw
		$error("accum_exec: AW must lie between 2 and 8.");
	end

	state_e          state_reg;
	state_e          state_next;
	cmd_s            cmd_reg;
	logic [7:0]      acc_reg;
	logic [7:0]      acc_next;
	flags_s          flags_reg;
	flags_s          flags_next;
	logic [7:0]      sp_reg;
	logic [7:0]      sp_next;
	logic [7:0]      maddr_reg;
	logic            ack_reg;
	logic [31:0]     prdata_reg;

	logic            mem_we;
	logic [AW-1:0]   mem_waddr;
	logic [7:0]      mem_wdata;
	logic [AW-1:0]   mem_raddr;
	logic [7:0]      mem_rdata;

	function automatic logic [AW-1:0] addr_of(input logic [7:0] v);
		return v[AW-1:0];
	endfunction : addr_of

	// Operand routing for each arithmetic command.
	function automatic ctrl_s op_ctrl(input op_e op);
		ctrl_s c;
		c = '{arith: 1'b1, mem_first: 1'b0, ysel: ysel_mem, use_c: 1'b0, is_sub: 1'b0, dest_mem: 1'b0};
		unique case (op)
			OP_IDXM_ST, OP_IDXM_LD, OP_XCH, OP_PUSHAF, OP_POPAF: c.arith = 1'b0;
			OP_ADD_AI:  c.ysel = ysel_imm;
			OP_ADD_AM:  c.ysel = ysel_mem;
			OP_ADD_MA:  c.dest_mem = 1'b1;
			OP_ADDC_AM: c.use_c = 1'b1;
			OP_ADDC_MA:
			begin
				c.use_c    = 1'b1;
				c.dest_mem = 1'b1;
			end
			OP_ADDC_A:
			begin
				c.ysel  = ysel_zero;
				c.use_c = 1'b1;
			end
			OP_ADDC_M:
			begin
				c.mem_first = 1'b1;
				c.ysel      = ysel_zero;
				c.use_c     = 1'b1;
				c.dest_mem  = 1'b1;
			end
			OP_NADD_AM:
			begin
				c.mem_first = 1'b1;
				c.ysel      = ysel_acc;
				c.is_sub    = 1'b1;
			end
			OP_NADD_MA:
			begin
				c.is_sub   = 1'b1;
				c.dest_mem = 1'b1;
			end
			OP_SUB_AI:
			begin
				c.ysel   = ysel_imm;
				c.is_sub = 1'b1;
			end
			OP_SUB_AM:  c.is_sub = 1'b1;
			OP_SUB_MA:
			begin
				c.mem_first = 1'b1;
				c.ysel      = ysel_acc;
				c.is_sub    = 1'b1;
				c.dest_mem  = 1'b1;
			end
		endcase
		return c;
	endfunction : op_ctrl

	// Bus decode. Every transfer has one wait state so that read data can come from a flip-flop.
	wire logic busy      = (state_reg != st_idle);
	wire logic sel_cmd   = (paddr == CMD_OFF);
	wire logic sel_acc   = (paddr == ACC_OFF);
	wire logic sel_flags = (paddr == FLAGS_OFF);
	wire logic sel_sp    = (paddr == SP_OFF);
	wire logic sel_stat  = (paddr == STATUS_OFF);
	wire logic sel_maddr = (paddr == MEM_ADDR_OFF);
	wire logic sel_mdata = (paddr == MEM_DATA_OFF);
	wire logic sel_any   = sel_cmd | sel_acc | sel_flags | sel_sp | sel_stat | sel_maddr | sel_mdata;
	wire logic op_legal  = (pwdata[CMD_OP_LSB +: 5] <= 5'(OP_SUB_MA));
	wire logic wr_locked = sel_cmd | sel_acc | sel_flags | sel_sp | sel_mdata;

	// Writing live core state mid-instruction would tear the result, so such writes are refused, as are memory data reads while busy.
	wire logic bus_err = !sel_any
		| (pwrite & busy & wr_locked)
		| (pwrite & sel_cmd & !op_legal)
		| (pwrite & sel_stat)
		| (!pwrite & busy & sel_mdata);

	wire logic access  = psel & penable;
	wire logic apb_wr  = access & ack_reg & pwrite & !bus_err;
	wire logic capture = access & !ack_reg & !pwrite;

	wire logic [31:0] rd_word =
		sel_cmd   ? {16'h0000, cmd_reg} :
		sel_acc   ? {24'h000000, acc_reg} :
		sel_flags ? {28'h0000000, flags_reg} :
		sel_sp    ? {24'h000000, sp_reg} :
		sel_stat  ? {31'h00000000, busy} :
		sel_maddr ? {24'h000000, maddr_reg} :
		sel_mdata ? {24'h000000, mem_rdata} :
		32'h00000000;

	assign pready  = ack_reg;
	assign pslverr = ack_reg & bus_err;
	assign prdata  = prdata_reg;

	// Datapath operands.
	wire op_e        op    = cmd_reg.op;
	wire logic [7:0] opnd  = cmd_reg.operand;
	wire ctrl_s      ctrl  = op_ctrl(op);
	wire logic [7:0] alu_x = ctrl.mem_first ? mem_rdata : acc_reg;
	wire logic [7:0] alu_y =
		(ctrl.ysel == ysel_imm)  ? opnd :
		(ctrl.ysel == ysel_acc)  ? acc_reg :
		(ctrl.ysel == ysel_zero) ? 8'h00 :
		mem_rdata;
	wire logic       alu_ci = ctrl.use_c & flags_reg.c;
	wire alu_s       alu    = alu_calc(alu_x, alu_y, alu_ci, ctrl.is_sub);

	// Sequencer: issue puts the first address on the read port, use sees its byte one cycle later.
	always_comb
	begin
		state_next = state_reg;
		acc_next   = acc_reg;
		flags_next = flags_reg;
		sp_next    = sp_reg;
		mem_we     = apb_wr & sel_mdata;
		mem_waddr  = addr_of(maddr_reg);
		mem_wdata  = pwdata[7:0];
		mem_raddr  = addr_of(maddr_reg);
		if (apb_wr & sel_acc)
		begin
			acc_next = pwdata[7:0];
		end
		if (apb_wr & sel_flags)
		begin
			flags_next = flags_s'(pwdata[3:0]);
		end
		if (apb_wr & sel_sp)
		begin
			sp_next = pwdata[7:0];
		end
		unique case (state_reg)
			st_idle:
			begin
				if (apb_wr & sel_cmd)
				begin
					state_next = st_issue;
				end
			end
			st_issue:
			begin
				state_next = st_use;
				mem_raddr  = addr_of(opnd);
				if (op == OP_PUSHAF)
				begin
					mem_we    = 1'b1;
					mem_waddr = addr_of(sp_reg);
					mem_wdata = acc_reg;
				end
				else if (op == OP_POPAF)
				begin
					sp_next   = sp_reg - SP_STEP;
					mem_raddr = addr_of(sp_reg - SP_STEP);
				end
			end
			st_use:
			begin
				state_next = st_idle;
				if (op == OP_IDXM_ST)
				begin
					// The pointer is the byte read at the operand address; only its low AW bits reach the memory.
					mem_we    = 1'b1;
					mem_waddr = addr_of(mem_rdata);
					mem_wdata = acc_reg;
				end
				else if (op == OP_IDXM_LD)
				begin
					mem_raddr  = addr_of(mem_rdata);
					state_next = st_finish;
				end
				else if (op == OP_XCH)
				begin
					mem_we    = 1'b1;
					mem_waddr = addr_of(opnd);
					mem_wdata = acc_reg;
					acc_next  = mem_rdata;
				end
				else if (op == OP_PUSHAF)
				begin
					mem_we    = 1'b1;
					mem_waddr = addr_of(sp_reg + 8'h01);
					mem_wdata = {4'h0, flags_reg};
					sp_next   = sp_reg + SP_STEP;
				end
				else if (op == OP_POPAF)
				begin
					mem_raddr  = addr_of(sp_reg + 8'h01);
					acc_next   = mem_rdata;
					state_next = st_finish;
				end
				else if (ctrl.arith)
				begin
					flags_next = alu.flags;
					if (ctrl.dest_mem)
					begin
						mem_we    = 1'b1;
						mem_waddr = addr_of(opnd);
						mem_wdata = alu.res;
					end
					else
					begin
						acc_next = alu.res;
					end
				end
			end
			st_finish:
			begin
				state_next = st_idle;
				if (op == OP_IDXM_LD)
				begin
					acc_next = mem_rdata;
				end
				else
				begin
					flags_next = flags_s'(mem_rdata[3:0]);
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= st_idle;
			acc_reg   <= ACC_RST;
			flags_reg <= flags_s'(FLAGS_RST);
			sp_reg    <= SP_RST;
		end
		else
		begin
			state_reg <= state_next;
			acc_reg   <= acc_next;
			flags_reg <= flags_next;
			sp_reg    <= sp_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_reg   <= cmd_s'(16'h0000);
			maddr_reg <= MADDR_RST;
		end
		else
		begin
			if (apb_wr & sel_cmd)
			begin
				cmd_reg <= cmd_s'(pwdata[15:0]);
			end
			if (apb_wr & sel_maddr)
			begin
				maddr_reg <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_reg    <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
		else
		begin
			ack_reg <= access & !ack_reg;
			if (capture)
			begin
				prdata_reg <= bus_err ? 32'h00000000 : rd_word;
			end
		end
	end

	data_ram #(
		.AW(AW)
	) u_ram (
		.pclk   (pclk),
		.presetn(presetn),
		.we     (mem_we),
		.waddr  (mem_waddr),
		.wdata  (mem_wdata),
		.raddr  (mem_raddr),
		.rdata  (mem_rdata)
	);

endmodule : accum_exec

`default_nettype wire

// file: src/data_ram.sv
// Byte-wide data memory and stack area with a registered read port.
`timescale 1ns/1ps
`default_nettype none

module data_ram #(
	parameter int AW = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);

	if (AW < 2 || AW > 8)
	begin : g_bad_aw
		$error("data_ram: AW must lie between 2 and 8.");
	end

	logic [7:0] mem [0:(1 << AW) - 1];

	always_ff @(posedge pclk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// A write and a read of the same byte in one cycle return the old byte; the swap reads in issue and writes in use.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata <= 8'h00;
		end
		else
		begin
			rdata <= mem[raddr];
		end
	end

endmodule : data_ram

`default_nettype wire
